/* File: slc_pkg.sv */
// constants and carriers for the synthesizer loop configuration bank
// assumes 32-bit serial words with the register address in the low four bits
package slc_pkg;
  // register addresses in bits 3:0
  localparam logic [3:0] SLC_ADDR_FREQ = 4'h0;
  localparam logic [3:0] SLC_ADDR_PHASE = 4'h2;
  localparam logic [3:0] SLC_ADDR_FINE = 4'h3;
  localparam logic [3:0] SLC_ADDR_AUX = 4'h4;
  localparam logic [3:0] SLC_ADDR_REFP = 4'h5;
  localparam logic [3:0] SLC_ADDR_LOOP = 4'h6;
  localparam logic [3:0] SLC_ADDR_LDT = 4'h7;
  // field positions
  localparam int SLC_R0_VARMOD_BIT = 28;
  localparam int SLC_R2_PHEN_BIT = 31;
  localparam int SLC_R2_PHASE_LSB = 4;
  localparam int SLC_R34_LSB = 4;
  localparam int SLC_R5_PINMODE_LSB = 30;
  localparam int SLC_R5_PUMP_LSB = 25;
  localparam int SLC_R5_LSBOFF_BIT = 24;
  localparam int SLC_R5_PRESC_BIT = 23;
  localparam int SLC_R5_HALVER_BIT = 22;
  localparam int SLC_R5_DOUBLER_BIT = 21;
  localparam int SLC_R5_RCOUNT_LSB = 16;
  localparam int SLC_R5_CLK1_LSB = 4;
  localparam int SLC_R6_BLEED_LSB = 24;
  localparam int SLC_R6_BLNEG_BIT = 23;
  localparam int SLC_R6_BLEN_BIT = 22;
  localparam int SLC_R6_SDMOFF_BIT = 20;
  localparam int SLC_R6_ABP_BIT = 19;
  localparam int SLC_R6_LOL_BIT = 18;
  localparam int SLC_R6_SDRST_BIT = 17;
  localparam int SLC_R6_CPTSPD_BIT = 16;
  localparam int SLC_R6_LDP_LSB = 8;
  localparam int SLC_R6_PD_BIT = 6;
  localparam int SLC_R6_CPTS_BIT = 5;
  localparam int SLC_R6_CRST_BIT = 4;
  localparam int SLC_R7_PRELOAD_LSB = 26;
  localparam int SLC_R7_RATE_BIT = 25;
  localparam int SLC_R7_NDLY_LSB = 20;
  // lock pin modes
  localparam logic [1:0] SLC_PIN_TRISTATE = 2'h0;
  localparam logic [1:0] SLC_PIN_LOCK = 2'h1;
  localparam logic [1:0] SLC_PIN_LOW = 2'h2;
  localparam logic [1:0] SLC_PIN_HIGH = 2'h3;
  // lock detector timing; slow check last in comparisons, the rest in core cycles
  localparam logic [4:0] SLC_SLOW_CHECK_LAST = 5'h1F;
  localparam logic [11:0] SLC_REF_LOSS_CYCLES = 12'h400;
  localparam logic [7:0] SLC_GAP_MAX = 8'hFF;
  // staged frequency-path fields, moved to active on a register zero write
  typedef struct packed {
    logic phase_step_enable;
    logic [11:0] phase_value;
    logic [23:0] fine_fraction_numerator;
    logic [23:0] auxiliary_modulus;
    logic [3:0] pump_current;
    logic extra_modulus_bit_off;
    logic prescaler_8_9;
    logic reference_halver;
    logic reference_doubler;
    logic [4:0] reference_count;
    logic [11:0] clk1_divider;
  } slc_freq_cfg_type;
  // loop and lock controls, effective at once
  typedef struct packed {
    logic [1:0] lock_pin_mode;
    logic [7:0] bleed_value;
    logic bleed_negative;
    logic bleed_enable;
    logic sigma_delta_modulator_off;
    logic backlash_narrow;
    logic reference_loss_unlock;
    logic sd_reset_off;
    logic cp_tristate_pd_on;
    logic [1:0] lock_window_precision;
    logic power_down;
    logic cp_tristate;
    logic counter_reset;
    logic [5:0] lock_counter_preload;
    logic lock_check_rate_select;
    logic [1:0] n_delay;
  } slc_loop_cfg_type;
  localparam slc_freq_cfg_type SLC_FREQ_RESET = '0;
  localparam slc_loop_cfg_type SLC_LOOP_RESET = '0;
endpackage : slc_pkg

/* File: slc_synth_loop_config_regs.sv */
// serial-loaded configuration bank for registers two to seven plus lock detector
// assumes a host shifting 32-bit words msb first on serial_clock_in and raising
// load_enable_in after the last bit, keeping the clock still while it is high
// Function
// - phase step applied on next register zero write
// - twelve-bit phase value sets step size
// - fine fraction, aux modulus ignored when fixed
// - lock pin mode 01 shows lock
// - four-bit charge pump current code
// - bit24 clear adds 26th modulus bit in fixed modulus
// - bit23 picks 4/5 or 8/9 prescaler
// - halver, doubler and reference count fields
// - bit20 turns the modulator fully off
// - reference loss drops lock when enabled
// - bit17 clear resets modulator on load
// - bits 16 and 5 three-state pump
// - lock needs edges inside precision window
// - bit6 powers down, registers kept
// - bit4 holds dividers in reset
// - check rate every comparison or 32nd
// - preload seeds the lock counter
// - frequency changes only on register zero
`timescale 1ns/10ps
module slc_synth_loop_config_regs (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic load_enable_in,
  input wire logic reference_edge_in,
  input wire logic feedback_edge_in,
  input wire logic [1:0] lock_bias_in,
  output slc_pkg::slc_freq_cfg_type freq_cfg_out,
  output slc_pkg::slc_loop_cfg_type loop_cfg_out,
  output logic fixed_modulus_out,
  output logic modulus_26bit_out,
  output logic load_strobe_out,
  output logic phase_step_pulse_out,
  output logic sdm_reset_pulse_out,
  output logic sdm_enable_out,
  output logic cp_tristate_out,
  output logic dividers_reset_out,
  output logic lock_detected_out,
  output logic lock_indicator_pin_out,
  output logic lock_indicator_pin_oe_out
);
  // lock window width in core cycles from precision and bias
  function automatic logic [7:0] slc_lock_window(input logic [1:0] prec,
                                                 input logic [1:0] bias);
    slc_lock_window = (8'h01 + {6'h00, prec}) << bias;
  endfunction : slc_lock_window

  typedef enum {SLC_PH_IDLE, SLC_PH_REF_FIRST, SLC_PH_FB_FIRST} slc_phase_state_type;

  logic [31:0] shift_r; // link-domain shifter
  logic [2:0] le_sync_r; // load enable synchroniser plus edge stage
  logic [2:0] ref_sync_r; // reference edge synchroniser plus edge stage
  logic [2:0] fb_sync_r; // feedback edge synchroniser plus edge stage
  logic [31:0] word_r; // captured serial word
  logic word_valid_r; // one-cycle flag for a fresh word
  slc_pkg::slc_freq_cfg_type staged_field_r; // waiting for register zero
  slc_pkg::slc_freq_cfg_type freq_r; // active frequency fields
  slc_pkg::slc_loop_cfg_type loop_r; // loop controls
  logic fixed_r; // fixed modulus chosen by last register zero
  logic load_r;
  logic phase_pulse_r;
  logic sdm_rst_r;
  logic [1:0] bias_r; // bias bits are same-clock logic, registered once
  slc_phase_state_type ph_state_r;
  logic [7:0] gap_r; // cycles between the two edges
  logic cmp_done_r; // one comparison finished
  logic cmp_good_r; // it fell inside the window
  logic [4:0] check_cnt_r; // slow check divider
  logic [5:0] lock_cnt_r; // counts down to lock
  logic locked_r;
  logic [11:0] ref_idle_r; // cycles since last reference edge
  logic pin_r;
  logic pin_oe_r;
  logic cp_ts_r;
  logic div_rst_r;
  logic sdm_en_r;
  logic mod26_r;

  logic le_rise;
  logic ref_rise;
  logic fb_rise;
  logic hold_lock; // dividers stopped or chip down
  logic check_now;
  logic [3:0] word_addr;

  assign le_rise = le_sync_r[1] & ~le_sync_r[2];
  assign ref_rise = ref_sync_r[1] & ~ref_sync_r[2];
  assign fb_rise = fb_sync_r[1] & ~fb_sync_r[2];
  assign hold_lock = loop_r.power_down | loop_r.counter_reset;
  assign word_addr = word_r[3:0];
  assign check_now = cmp_done_r &
                     (loop_r.lock_check_rate_select | (check_cnt_r == slc_pkg::SLC_SLOW_CHECK_LAST));

  // link-side shifter, msb first; clock stands still outside frames
  always_ff @(posedge serial_clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[30:0], serial_data_in};
    end
  end

  // synchronisers; only stages 1 and 2 feed logic
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      le_sync_r <= '0;
      ref_sync_r <= '0;
      fb_sync_r <= '0;
      bias_r <= '0;
    end else begin
      le_sync_r <= {le_sync_r[1:0], load_enable_in};
      ref_sync_r <= {ref_sync_r[1:0], reference_edge_in};
      fb_sync_r <= {fb_sync_r[1:0], feedback_edge_in};
      bias_r <= lock_bias_in;
    end
  end

  // word capture; shifter is quiet while load enable is high, so it is stable here
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_r <= '0;
      word_valid_r <= 1'b0;
    end else begin
      word_valid_r <= le_rise;
      if (le_rise) begin
        word_r <= shift_r;
      end
    end
  end

  // staged fields of registers two to five
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      staged_field_r <= slc_pkg::SLC_FREQ_RESET;
    end else if (word_valid_r) begin
      unique case (word_addr)
        slc_pkg::SLC_ADDR_PHASE: begin
          staged_field_r.phase_step_enable <= word_r[slc_pkg::SLC_R2_PHEN_BIT];
          staged_field_r.phase_value <= word_r[slc_pkg::SLC_R2_PHASE_LSB +: 12];
        end
        slc_pkg::SLC_ADDR_FINE: begin
          staged_field_r.fine_fraction_numerator <= word_r[slc_pkg::SLC_R34_LSB +: 24];
        end
        slc_pkg::SLC_ADDR_AUX: begin
          staged_field_r.auxiliary_modulus <= word_r[slc_pkg::SLC_R34_LSB +: 24];
        end
        slc_pkg::SLC_ADDR_REFP: begin
          staged_field_r.pump_current <= word_r[slc_pkg::SLC_R5_PUMP_LSB +: 4];
          staged_field_r.extra_modulus_bit_off <= word_r[slc_pkg::SLC_R5_LSBOFF_BIT];
          staged_field_r.prescaler_8_9 <= word_r[slc_pkg::SLC_R5_PRESC_BIT];
          staged_field_r.reference_halver <= word_r[slc_pkg::SLC_R5_HALVER_BIT];
          staged_field_r.reference_doubler <= word_r[slc_pkg::SLC_R5_DOUBLER_BIT];
          staged_field_r.reference_count <= word_r[slc_pkg::SLC_R5_RCOUNT_LSB +: 5];
          staged_field_r.clk1_divider <= word_r[slc_pkg::SLC_R5_CLK1_LSB +: 12];
        end
        default: begin
          // other addresses leave staging alone
        end
      endcase
    end
  end

  // immediate loop controls of registers five to seven
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loop_r <= slc_pkg::SLC_LOOP_RESET;
    end else if (word_valid_r) begin
      if (word_addr == slc_pkg::SLC_ADDR_REFP) begin
        loop_r.lock_pin_mode <= word_r[slc_pkg::SLC_R5_PINMODE_LSB +: 2];
      end
      if (word_addr == slc_pkg::SLC_ADDR_LOOP) begin
        loop_r.bleed_value <= word_r[slc_pkg::SLC_R6_BLEED_LSB +: 8];
        loop_r.bleed_negative <= word_r[slc_pkg::SLC_R6_BLNEG_BIT];
        loop_r.bleed_enable <= word_r[slc_pkg::SLC_R6_BLEN_BIT];
        loop_r.sigma_delta_modulator_off <= word_r[slc_pkg::SLC_R6_SDMOFF_BIT];
        loop_r.backlash_narrow <= word_r[slc_pkg::SLC_R6_ABP_BIT];
        loop_r.reference_loss_unlock <= word_r[slc_pkg::SLC_R6_LOL_BIT];
        loop_r.sd_reset_off <= word_r[slc_pkg::SLC_R6_SDRST_BIT];
        loop_r.cp_tristate_pd_on <= word_r[slc_pkg::SLC_R6_CPTSPD_BIT];
        loop_r.lock_window_precision <= word_r[slc_pkg::SLC_R6_LDP_LSB +: 2];
        loop_r.power_down <= word_r[slc_pkg::SLC_R6_PD_BIT];
        loop_r.cp_tristate <= word_r[slc_pkg::SLC_R6_CPTS_BIT];
        loop_r.counter_reset <= word_r[slc_pkg::SLC_R6_CRST_BIT];
      end
      if (word_addr == slc_pkg::SLC_ADDR_LDT) begin
        loop_r.lock_counter_preload <= word_r[slc_pkg::SLC_R7_PRELOAD_LSB +: 6];
        loop_r.lock_check_rate_select <= word_r[slc_pkg::SLC_R7_RATE_BIT];
        loop_r.n_delay <= word_r[slc_pkg::SLC_R7_NDLY_LSB +: 2];
      end
    end
  end

  // register zero write: transfer staged fields and fire the load events
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      freq_r <= slc_pkg::SLC_FREQ_RESET;
      fixed_r <= 1'b1;
      load_r <= 1'b0;
      phase_pulse_r <= 1'b0;
      sdm_rst_r <= 1'b0;
    end else begin
      // only register zero loads the frequency path
      load_r <= word_valid_r & (word_addr == slc_pkg::SLC_ADDR_FREQ);
      phase_pulse_r <= word_valid_r & (word_addr == slc_pkg::SLC_ADDR_FREQ) &
                       staged_field_r.phase_step_enable;
      // modulator reset on load unless disabled
      sdm_rst_r <= word_valid_r & (word_addr == slc_pkg::SLC_ADDR_FREQ) &
                   ~loop_r.sd_reset_off;
      if (word_valid_r && word_addr == slc_pkg::SLC_ADDR_FREQ) begin
        freq_r <= staged_field_r;
        fixed_r <= ~word_r[slc_pkg::SLC_R0_VARMOD_BIT];
      end
    end
  end

  // derived control levels
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cp_ts_r <= 1'b0;
      div_rst_r <= 1'b0;
      sdm_en_r <= 1'b0;
      mod26_r <= 1'b0;
    end else begin
      cp_ts_r <= loop_r.cp_tristate_pd_on | loop_r.cp_tristate | loop_r.power_down;
      div_rst_r <= loop_r.counter_reset | loop_r.power_down;
      sdm_en_r <= ~loop_r.sigma_delta_modulator_off & ~loop_r.power_down;
      mod26_r <= fixed_r & ~freq_r.extra_modulus_bit_off;
    end
  end

  // edge pair timing: measure gap from first edge to the other
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ph_state_r <= SLC_PH_IDLE;
      gap_r <= '0;
      cmp_done_r <= 1'b0;
      cmp_good_r <= 1'b0;
    end else begin
      cmp_done_r <= 1'b0;
      if (hold_lock) begin
        // no edges reach the detector while dividers are held
        ph_state_r <= SLC_PH_IDLE;
        gap_r <= '0;
      end else begin
        unique case (ph_state_r)
          SLC_PH_IDLE: begin
            gap_r <= 8'h01;
            if (ref_rise && fb_rise) begin
              cmp_done_r <= 1'b1;
              cmp_good_r <= 1'b1;
            end else if (ref_rise) begin
              ph_state_r <= SLC_PH_REF_FIRST;
            end else if (fb_rise) begin
              ph_state_r <= SLC_PH_FB_FIRST;
            end
          end
          SLC_PH_REF_FIRST, SLC_PH_FB_FIRST: begin
            if ((ph_state_r == SLC_PH_REF_FIRST && fb_rise) ||
                (ph_state_r == SLC_PH_FB_FIRST && ref_rise) || gap_r == slc_pkg::SLC_GAP_MAX) begin
              cmp_done_r <= 1'b1;
              cmp_good_r <= (gap_r < slc_lock_window(loop_r.lock_window_precision, bias_r)) &&
                            (gap_r != slc_pkg::SLC_GAP_MAX);
              ph_state_r <= SLC_PH_IDLE;
            end else begin
              gap_r <= gap_r + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // reference activity watchdog
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ref_idle_r <= '0;
    end else if (ref_rise) begin
      ref_idle_r <= '0;
    end else if (ref_idle_r != slc_pkg::SLC_REF_LOSS_CYCLES) begin
      ref_idle_r <= ref_idle_r + 12'h001;
    end
  end

  // lock counter; stays locked only while checks keep passing
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      check_cnt_r <= '0;
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (hold_lock) begin
      check_cnt_r <= '0;
      lock_cnt_r <= loop_r.lock_counter_preload;
      locked_r <= 1'b0;
    end else begin
      if (cmp_done_r) begin
        check_cnt_r <= check_cnt_r + 5'h01;
      end
      if (loop_r.reference_loss_unlock && locked_r &&
          ref_idle_r == slc_pkg::SLC_REF_LOSS_CYCLES) begin
        locked_r <= 1'b0;
        lock_cnt_r <= loop_r.lock_counter_preload;
      end else if (check_now && !cmp_good_r) begin
        locked_r <= 1'b0;
        lock_cnt_r <= loop_r.lock_counter_preload;
      end else if (check_now) begin
        if (lock_cnt_r == 6'h00) begin
          locked_r <= 1'b1;
        end else begin
          lock_cnt_r <= lock_cnt_r - 6'h01;
        end
      end
    end
  end

  // lock indicator pin driver
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      unique case (loop_r.lock_pin_mode)
        slc_pkg::SLC_PIN_TRISTATE: begin
          pin_r <= 1'b0;
          pin_oe_r <= 1'b0;
        end
        slc_pkg::SLC_PIN_LOCK: begin
          pin_r <= locked_r;
          pin_oe_r <= 1'b1;
        end
        slc_pkg::SLC_PIN_LOW: begin
          pin_r <= 1'b0;
          pin_oe_r <= 1'b1;
        end
        slc_pkg::SLC_PIN_HIGH: begin
          pin_r <= 1'b1;
          pin_oe_r <= 1'b1;
        end
      endcase
    end
  end

  // fine fraction and aux modulus zeroed in fixed mode
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      freq_cfg_out <= slc_pkg::SLC_FREQ_RESET;
    end else begin
      freq_cfg_out <= freq_r;
      if (fixed_r) begin
        freq_cfg_out.fine_fraction_numerator <= '0;
        freq_cfg_out.auxiliary_modulus <= '0;
      end
    end
  end

  // remaining outputs straight from flops
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loop_cfg_out <= slc_pkg::SLC_LOOP_RESET;
      fixed_modulus_out <= 1'b1;
      lock_detected_out <= 1'b0;
    end else begin
      loop_cfg_out <= loop_r;
      fixed_modulus_out <= fixed_r;
      lock_detected_out <= locked_r;
    end
  end

  assign modulus_26bit_out = mod26_r;
  assign load_strobe_out = load_r;
  assign phase_step_pulse_out = phase_pulse_r;
  assign sdm_reset_pulse_out = sdm_rst_r;
  assign sdm_enable_out = sdm_en_r;
  assign cp_tristate_out = cp_ts_r;
  assign dividers_reset_out = div_rst_r;
  assign lock_indicator_pin_out = pin_r;
  assign lock_indicator_pin_oe_out = pin_oe_r;
endmodule : slc_synth_loop_config_regs

/* File: slc_regs_asserts.sv */
// concurrent checks on the configuration bank outputs
// assumes binding onto the bank top, a single core clock domain
`timescale 1ns/10ps
module slc_regs_asserts (
  input wire logic clock_in,
  input wire logic resetn_in,
  input slc_pkg::slc_freq_cfg_type freq_cfg_out,
  input slc_pkg::slc_loop_cfg_type loop_cfg_out,
  input wire logic fixed_modulus_out,
  input wire logic modulus_26bit_out,
  input wire logic load_strobe_out,
  input wire logic phase_step_pulse_out,
  input wire logic sdm_reset_pulse_out,
  input wire logic sdm_enable_out,
  input wire logic cp_tristate_out,
  input wire logic dividers_reset_out,
  input wire logic lock_detected_out,
  input wire logic lock_indicator_pin_out,
  input wire logic lock_indicator_pin_oe_out
);
  // one core clock, reset silences everything
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  pulse_needs_load_a: assert property (
    (phase_step_pulse_out || sdm_reset_pulse_out) |-> load_strobe_out)
    else $error("event pulse without load strobe");
  sdm_reset_a: assert property (
    load_strobe_out |-> sdm_reset_pulse_out == !loop_cfg_out.sd_reset_off)
    else $error("modulator reset pulse wrong");
  load_single_a: assert property (load_strobe_out |=> !load_strobe_out)
    else $error("load strobe longer than one cycle");
  fixed_ignore_a: assert property (fixed_modulus_out |->
    freq_cfg_out.fine_fraction_numerator == 0 && freq_cfg_out.auxiliary_modulus == 0)
    else $error("fine fields visible in fixed modulus");
  pump_tristate_a: assert property (cp_tristate_out ==
    (loop_cfg_out.cp_tristate_pd_on || loop_cfg_out.cp_tristate || loop_cfg_out.power_down))
    else $error("pump tristate mismatch");
  divider_hold_a: assert property (dividers_reset_out ==
    (loop_cfg_out.counter_reset || loop_cfg_out.power_down))
    else $error("divider reset mismatch");
  sdm_off_a: assert property ($past(resetn_in) |-> sdm_enable_out ==
    !(loop_cfg_out.sigma_delta_modulator_off || loop_cfg_out.power_down))
    else $error("modulator enable mismatch");
  mod26_a: assert property ($past(resetn_in) |-> modulus_26bit_out ==
    (fixed_modulus_out && !freq_cfg_out.extra_modulus_bit_off))
    else $error("extra modulus bit wrong");
  pin_off_a: assert property (
    (loop_cfg_out.lock_pin_mode == slc_pkg::SLC_PIN_TRISTATE) [*3] |-> !lock_indicator_pin_oe_out)
    else $error("lock pin driven in off mode");
  pin_lock_a: assert property ((loop_cfg_out.lock_pin_mode == slc_pkg::SLC_PIN_LOCK
    && $stable(lock_detected_out)) [*3] |->
    lock_indicator_pin_oe_out && lock_indicator_pin_out == lock_detected_out)
    else $error("lock pin does not follow lock");
  power_lock_a: assert property (loop_cfg_out.power_down [*5] |-> !lock_detected_out)
    else $error("lock held in power down");
endmodule : slc_regs_asserts

/* File: slc_host_model.sv */
// host model shifting words into the serial write port
// assumes the bench calls send_word and waits until it returns
`timescale 1ns/10ps
module slc_host_model (
  output logic sclk_out,
  output logic sdata_out,
  output logic le_out
);
  // idle link: clock still, enable low
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    le_out = 1'b0;
  end
  // 32 bits, msb first, address last
  task automatic send_word(input logic [31:0] word);
    #17;
    for (int i = 31; i >= 0; i--) begin
      sdata_out = word[i];
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
    end
    // released data line shows the inverse, not the last bit
    sdata_out = ~word[0];
    // clock stays still while enable is high and a while after
    #20 le_out = 1'b1;
    #80 le_out = 1'b0;
    #40;
  endtask : send_word
endmodule : slc_host_model

/* File: slc_synth_loop_config_regs_tb.sv */
// self-checking bench for the loop configuration bank
// assumes the host model drives the serial port; the bench makes the edges
`timescale 1ns/10ps
module slc_synth_loop_config_regs_tb;
  logic clock_in, resetn_in, serial_clock_in, serial_data_in, load_enable_in;
  logic reference_edge_in = 1'b0, feedback_edge_in = 1'b0, ref_on, fb_late;
  logic [1:0] lock_bias_in;
  logic [3:0] ref_cnt = 4'h0;
  logic [7:0] hist = 8'h00;
  slc_pkg::slc_freq_cfg_type freq_cfg_out;
  slc_pkg::slc_loop_cfg_type loop_cfg_out;
  logic fixed_modulus_out, modulus_26bit_out, load_strobe_out, phase_step_pulse_out;
  logic sdm_reset_pulse_out, sdm_enable_out, cp_tristate_out, dividers_reset_out;
  logic lock_detected_out, lock_indicator_pin_out, lock_indicator_pin_oe_out;
  int fail_count = 0, checked = 0, n_load = 0, n_phase = 0, n_sdm = 0;
  slc_synth_loop_config_regs u_slc_synth_loop_config_regs (.clock_in, .resetn_in,
    .serial_clock_in, .serial_data_in, .load_enable_in, .reference_edge_in,
    .feedback_edge_in, .lock_bias_in, .freq_cfg_out, .loop_cfg_out, .fixed_modulus_out,
    .modulus_26bit_out, .load_strobe_out, .phase_step_pulse_out, .sdm_reset_pulse_out,
    .sdm_enable_out, .cp_tristate_out, .dividers_reset_out, .lock_detected_out,
    .lock_indicator_pin_out, .lock_indicator_pin_oe_out);
  slc_host_model u_slc_host_model (.sclk_out(serial_clock_in), .sdata_out(serial_data_in),
    .le_out(load_enable_in));
  // core clock, 8 ns
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // reference every 16 cycles; feedback same cycle or late
  always @(negedge clock_in) begin
    ref_cnt <= ref_cnt + 4'h1;
    reference_edge_in <= ref_on & ref_cnt[3];
    hist <= {hist[6:0], reference_edge_in};
    feedback_edge_in <= fb_late ? hist[1] : (ref_on & ref_cnt[3]);
  end
  // event pulse tallies
  always @(posedge clock_in) begin
    n_load += (load_strobe_out === 1'b1);
    n_phase += (phase_step_pulse_out === 1'b1);
    n_sdm += (sdm_reset_pulse_out === 1'b1);
  end
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] w);
    u_slc_host_model.send_word(w);
    repeat (8) @(negedge clock_in);
  endtask : wr
  function automatic logic [31:0] sel(input int n);
    return 32'h1 << n;
  endfunction : sel
  function automatic logic [31:0] w5(input logic [1:0] pin, input logic lsb_off);
    return {pin, 1'b0, 4'hA, lsb_off, 1'b1, 1'b1, 1'b0, 5'h11, 12'h000, 4'h5};
  endfunction : w5
  // timing adjust always written as 00
  function automatic logic [31:0] w7(input logic rate);
    return {6'h02, rate, 3'h0, 2'h0, 16'h0000, 4'h7};
  endfunction : w7
  // staged words wait for register zero
  task automatic t_stage();
    slc_pkg::slc_freq_cfg_type e;
    e = slc_pkg::SLC_FREQ_RESET;
    e.phase_step_enable = 1'b1;
    e.phase_value = 12'h200;
    e.fine_fraction_numerator = 24'h123456;
    e.auxiliary_modulus = 24'h00ABCD;
    e.pump_current = 4'hA;
    e.prescaler_8_9 = 1'b1;
    e.reference_halver = 1'b1;
    e.reference_count = 5'h11;
    wr({1'b1, 15'h0000, 12'h200, 4'h2});
    wr({4'h0, 24'h123456, 4'h3});
    wr({4'h0, 24'h00ABCD, 4'h4});
    wr(w5(2'h1, 1'b0));
    check(freq_cfg_out, slc_pkg::SLC_FREQ_RESET);
    // integer value 100 inside prescaler limits
    wr({3'h0, 1'b1, 28'h0000640});
    check(freq_cfg_out, e);
    check({n_load, n_phase, n_sdm, fixed_modulus_out}, {32'd1, 32'd1, 32'd1, 1'b0});
    wr({3'h0, 1'b0, 28'h0000640});
    check({freq_cfg_out.fine_fraction_numerator, modulus_26bit_out}, 25'h1);
    // unused phase step written as zero
    wr(32'h00000002);
    wr(w5(2'h1, 1'b1));
    wr({3'h0, 1'b0, 28'h0000640});
    check({modulus_26bit_out, n_phase}, {1'b0, 32'd2});
  endtask : t_stage
  // loop controls act at once
  task automatic t_loop();
    int bits[5] = '{20, 16, 5, 4, 6};
    logic [2:0] exp[5] = '{3'h0, 3'h6, 3'h6, 3'h5, 3'h3};
    int n;
    wr(32'h0000000C);
    for (int k = 0; k < 5; k++) begin
      wr(32'h6 | sel(bits[k]));
      check({sdm_enable_out, cp_tristate_out, dividers_reset_out}, exp[k]);
    end
    check(freq_cfg_out.reference_count, 5'h11);
    wr(32'h6 | sel(slc_pkg::SLC_R6_SDRST_BIT));
    n = n_sdm;
    wr({3'h0, 1'b1, 28'h0000640});
    check({n_sdm, sdm_enable_out}, {n, 1'b1});
    n = n_load;
    wr(32'hFFFFFFF8);
    check({n_load, loop_cfg_out.power_down}, {n, 1'b0});
  endtask : t_loop
  task automatic t_pin();
    for (int m = 0; m < 4; m++) begin
      wr(w5(m[1:0], 1'b1));
      check({lock_indicator_pin_oe_out, lock_indicator_pin_out}, {m != 0, m == 3});
    end
  endtask : t_pin
  // lock count, window, check rate and reference loss
  task automatic t_lock();
    wr(w5(2'h1, 1'b1));
    wr(w7(1'b1));
    wr(32'h6 | sel(slc_pkg::SLC_R6_PD_BIT));
    // bleed 99: code A, 100 MHz, negative, fractional
    wr(32'h63C00006 | sel(slc_pkg::SLC_R6_LOL_BIT) | sel(slc_pkg::SLC_R6_SDRST_BIT));
    check({loop_cfg_out.bleed_value, loop_cfg_out.bleed_negative,
           loop_cfg_out.bleed_enable}, 10'h18F);
    check(loop_cfg_out.lock_counter_preload, 6'h02);
    ref_on = 1'b1;
    repeat (24) @(negedge clock_in);
    check(lock_detected_out, 1'b0);
    repeat (100) @(negedge clock_in);
    check({lock_detected_out, lock_indicator_pin_out}, 2'h3);
    fb_late = 1'b1;
    repeat (60) @(negedge clock_in);
    check(lock_detected_out, 1'b0);
    // wider window from bias takes the late edge
    lock_bias_in = 2'h2;
    repeat (80) @(negedge clock_in);
    check(lock_detected_out, 1'b1);
    lock_bias_in = 2'h0;
    wr(w7(1'b0));
    fb_late = 1'b0;
    repeat (200) @(negedge clock_in);
    check(lock_detected_out, 1'b0);
    repeat (1700) @(negedge clock_in);
    check(lock_detected_out, 1'b1);
    ref_on = 1'b0;
    repeat (900) @(negedge clock_in);
    check(lock_detected_out, 1'b1);
    repeat (200) @(negedge clock_in);
    check(lock_detected_out, 1'b0);
  endtask : t_lock
  // watchdog well beyond the expected run
  initial begin
    #400us;
    fail_count++;
    stop_test();
  end
  // main sequence
  initial begin
    resetn_in = 1'b0;
    lock_bias_in = 2'h0;
    ref_on = 1'b0;
    fb_late = 1'b0;
    repeat (4) @(negedge clock_in);
    resetn_in = 1'b1;
    t_stage();
    t_loop();
    t_pin();
    t_lock();
    stop_test();
  end
endmodule : slc_synth_loop_config_regs_tb
bind slc_synth_loop_config_regs slc_regs_asserts u_slc_regs_asserts (.clock_in, .resetn_in,
  .freq_cfg_out, .loop_cfg_out, .fixed_modulus_out, .modulus_26bit_out, .load_strobe_out,
  .phase_step_pulse_out, .sdm_reset_pulse_out, .sdm_enable_out, .cp_tristate_out,
  .dividers_reset_out, .lock_detected_out, .lock_indicator_pin_out,
  .lock_indicator_pin_oe_out);
